/* File: tmif_consts.svh */
// tmif_consts.svh: offsets, bit positions, reset values and mode codes
`ifndef TMIF_CONSTS_SVH
`define TMIF_CONSTS_SVH

`define TMIF_ADDR_W 12
`define TMIF_OFS_INT_ENABLE 12'h000
`define TMIF_OFS_EXT_INT_ENABLE 12'h004
`define TMIF_OFS_INT_FLAGS 12'h008
`define TMIF_OFS_EXT_INT_FLAGS 12'h00C

`define TMIF_RST_REG 8'h00
`define TMIF_RST_EXT 6'h00
`define TMIF_RST_FLAGS 10'h000
`define TMIF_RST_PRDATA 32'h00000000

`define TMIF_NUM_SRC 10
`define TMIF_STD_SRCS 4
`define TMIF_STD_TOP 5
`define TMIF_EXT_TOP 9

`define TMIF_BIT_CAP 5
`define TMIF_BIT_CMPA 4
`define TMIF_BIT_CMPB 3
`define TMIF_BIT_OVF 2
`define TMIF_BIT_T3_CMPC 1
`define TMIF_BIT_T1_CMPC 0

`define TMIF_SRC_T1_CAP 0
`define TMIF_SRC_T1_CMPA 1
`define TMIF_SRC_T1_CMPB 2
`define TMIF_SRC_T1_OVF 3
`define TMIF_SRC_T3_CAP 4
`define TMIF_SRC_T3_CMPA 5
`define TMIF_SRC_T3_CMPB 6
`define TMIF_SRC_T3_OVF 7
`define TMIF_SRC_T3_CMPC 8
`define TMIF_SRC_T1_CMPC 9

`define TMIF_WGM_NORMAL 4'h0
`define TMIF_WGM_CTC_CMP 4'h4
`define TMIF_WGM_CTC_CAP 4'hC
`define TMIF_WGM_CAPTOP_BIT 3

`endif

/* File: tmif_pkg.sv */
// tmif_pkg.sv: types shared by the timer interrupt flag logic
package tmif_pkg;
  typedef logic [7:0] tmif_reg_t;
  typedef logic [9:0] tmif_src_vec_t;
  typedef logic [3:0] tmif_wgm_t;
  typedef logic [4:0] tmif_evt_t;
endpackage

/* File: tmif_ctrl.sv */
// tmif_ctrl.sv: timer interrupt enables, event flags and requests on APB
`timescale 1ns/100ps
`include "tmif_consts.svh"

// Overview of operation
// R1 - t1 capture request: enable, global, flag
// R2 - t1 compare A request: enable, global, flag
// R3 - t1 compare B request: enable, global, flag
// R4 - t1 overflow request: enable, global, flag
// R5 - t3 capture request: extended enable, global, flag
// R6 - t3 compare A request: extended enable, global, flag
// R7 - t3 compare B request: extended enable, global, flag
// R8 - t3 overflow request: extended enable, global, flag
// R9 - t3 compare C request: extended enable, global, flag
// R10 - t1 compare C request: extended enable, global, flag
// R11 - software writes reserved mask bits as zero
// R12 - legacy mode hides extended mask register
// R13 - capture pin event sets t1 capture flag
// R14 - capture-as-top mode: top sets capture flag
// R15 - capture flag cleared by vector or one
// R16 - compare A flag set tick after match
// R17 - compare B flag set tick after match
// R18 - forced compare strobe never sets flags
// R19 - compare flags cleared by vector or one
// R20 - overflow flag source follows waveform mode
// R21 - overflow flag cleared by vector or one
// R22 - t3 compare flags set tick after match
// R23 - extended flags share one register layout
// R24 - writing zero leaves a flag unchanged
module tmif_ctrl
  import tmif_pkg::*;
#(
  parameter int CNT_W = 16
)
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`TMIF_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic globalIntEnable,
  input wire logic legacyModePin,
  input wire tmif_src_vec_t vecAck,
  input wire logic [1:0] timerTick,
  input wire logic [1:0] capturePin,
  input wire logic [1:0][CNT_W-1:0] timerCounter,
  input wire logic [1:0][CNT_W-1:0] captureValue,
  input wire logic [1:0][CNT_W-1:0] compareAValue,
  input wire logic [1:0][CNT_W-1:0] compareBValue,
  input wire logic [1:0][CNT_W-1:0] compareCValue,
  input wire tmif_wgm_t [1:0] waveformModeSelect,
  input wire logic [1:0] overflowEvt,
  input wire logic [1:0] modeTovEvt,
  output tmif_src_vec_t irqReq
);

  generate
    if (CNT_W < 2 || CNT_W > 32)
    begin : g_badWidth
      $error("tmif_ctrl: CNT_W must lie in 2..32");
    end
  endgenerate

  // apb decode; zero wait states, so pready is tied high
  wire setupPh = psel & ~penable;
  wire accessPh = psel & penable;
  wire hitEn = paddr == `TMIF_OFS_INT_ENABLE;
  wire hitExtEn = paddr == `TMIF_OFS_EXT_INT_ENABLE;
  wire hitFlag = paddr == `TMIF_OFS_INT_FLAGS;
  wire hitExtFlag = paddr == `TMIF_OFS_EXT_INT_FLAGS;
  wire hitAny = hitEn | hitExtEn | hitFlag | hitExtFlag;
  wire wrAcc = accessPh & pwrite;

  assign pready = 1'b1;
  assign pslverr = accessPh & ~hitAny;

  logic legacySync1_q;
  logic legacySync2_q;
  wire legacyMode = legacySync2_q;

  tmif_reg_t intEnable_q;
  logic [5:0] extIntEnable_q;
  tmif_src_vec_t flags_q;
  tmif_src_vec_t flags_d;
  tmif_src_vec_t setVec;
  tmif_src_vec_t effEn;
  tmif_src_vec_t irqReq_q;
  logic [31:0] prdata_q;

  wire wrEn = wrAcc & hitEn;
  // extended mask is absent in legacy mode: writes dropped
  // R12 legacy write block
  wire wrExtEn = wrAcc & hitExtEn & ~legacyMode;
  wire wrFlag = wrAcc & hitFlag;
  wire wrExtFlag = wrAcc & hitExtFlag;

  // fuse level comes from outside, so it is synchronised first
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      legacySync1_q <= 1'b0;
      legacySync2_q <= 1'b0;
    end
    else
    begin
      legacySync1_q <= legacyModePin;
      legacySync2_q <= legacySync1_q;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      intEnable_q <= `TMIF_RST_REG;
    else if (wrEn)
      intEnable_q <= pwdata[7:0];
  end

  // reserved bits 7:6 are not stored and read back as zero
  // R11 reserved bits dropped
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      extIntEnable_q <= `TMIF_RST_EXT;
    else if (wrExtEn)
      extIntEnable_q <= pwdata[5:0];
  end

  // capture pins: two stages, then a third for edge detection
  logic [1:0] pinSync1_q;
  logic [1:0] pinSync2_q;
  logic [1:0] pinLast_q;

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      pinSync1_q <= 2'h0;
      pinSync2_q <= 2'h0;
      pinLast_q <= 2'h0;
    end
    else
    begin
      pinSync1_q <= capturePin;
      pinSync2_q <= pinSync1_q;
      pinLast_q <= pinSync2_q;
    end
  end

  tmif_evt_t [1:0] rawEvt;

  // per timer: raw events in order cap, cmpA, cmpB, cmpC, ovf
  genvar t;
  generate
    for (t = 0; t < 2; t++)
    begin : g_tmr
      logic [3:0] pend_q;
      wire [3:0] matchNow;
      wire capTop;
      wire tovPlain;
      wire pinEvt;
      wire [3:0] matchEvt;

      assign capTop = waveformModeSelect[t][`TMIF_WGM_CAPTOP_BIT] &
                      ~waveformModeSelect[t][0];
      assign tovPlain = waveformModeSelect[t] == `TMIF_WGM_NORMAL ||
                        waveformModeSelect[t] == `TMIF_WGM_CTC_CMP ||
                        waveformModeSelect[t] == `TMIF_WGM_CTC_CAP;
      assign pinEvt = pinSync2_q[t] & ~pinLast_q[t];

      // only counter equality arms a flag; force strobes never enter
      // R18 no forced set
      assign matchNow[0] = timerCounter[t] == compareAValue[t];
      assign matchNow[1] = timerCounter[t] == compareBValue[t];
      assign matchNow[2] = timerCounter[t] == compareCValue[t];
      // R14 top in capture mode
      assign matchNow[3] = capTop & (timerCounter[t] == captureValue[t]);

      // match seen on one tick raises the flag on the next tick
      // R16 R17 R22 one tick delay
      always_ff @(posedge clk_sys or negedge rstn)
      begin
        if (!rstn)
          pend_q <= 4'h0;
        else if (timerTick[t])
          pend_q <= matchNow;
      end

      assign matchEvt = pend_q & {4{timerTick[t]}};

      // pin capture is ignored while the capture value is the top
      // R13 R14 capture sources
      assign rawEvt[t][0] = (pinEvt & ~capTop) | matchEvt[3];
      assign rawEvt[t][1] = matchEvt[0];
      assign rawEvt[t][2] = matchEvt[1];
      assign rawEvt[t][3] = matchEvt[2];
      // R20 overflow source by mode
      assign rawEvt[t][4] = tovPlain ? overflowEvt[t] : modeTovEvt[t];
    end
  endgenerate

  assign setVec[`TMIF_SRC_T1_CAP] = rawEvt[0][0];
  assign setVec[`TMIF_SRC_T1_CMPA] = rawEvt[0][1];
  assign setVec[`TMIF_SRC_T1_CMPB] = rawEvt[0][2];
  assign setVec[`TMIF_SRC_T1_OVF] = rawEvt[0][4];
  assign setVec[`TMIF_SRC_T3_CAP] = rawEvt[1][0];
  assign setVec[`TMIF_SRC_T3_CMPA] = rawEvt[1][1];
  assign setVec[`TMIF_SRC_T3_CMPB] = rawEvt[1][2];
  assign setVec[`TMIF_SRC_T3_OVF] = rawEvt[1][4];
  assign setVec[`TMIF_SRC_T3_CMPC] = rawEvt[1][3];
  assign setVec[`TMIF_SRC_T1_CMPC] = rawEvt[0][3];

  // sources 0..3 live in the standard registers, 4..9 in the extended
  genvar i;
  generate
    for (i = 0; i < `TMIF_NUM_SRC; i++)
    begin : g_src
      localparam int BITP = (i < `TMIF_STD_SRCS) ?
                            `TMIF_STD_TOP - i : `TMIF_EXT_TOP - i;
      wire wrClr;
      wire clr;
      if (i < `TMIF_STD_SRCS)
      begin : g_std
        // R1 R2 R3 R4 standard enables
        assign effEn[i] = intEnable_q[BITP];
        assign wrClr = wrFlag & pwdata[BITP];
      end
      else
      begin : g_ext
        // R5 R6 R7 R8 R9 R10 extended enables, gone in legacy mode
        // R12 legacy masks out
        assign effEn[i] = extIntEnable_q[BITP] & ~legacyMode;
        // R23 extended flag layout
        assign wrClr = wrExtFlag & pwdata[BITP];
      end
      // R15 R19 R21 vector or one clears
      assign clr = wrClr | vecAck[i];
      // new event beats a clear in the same cycle; zero writes keep
      // R24 zero keeps flag
      assign flags_d[i] = setVec[i] | (flags_q[i] & ~clr);
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      flags_q <= `TMIF_RST_FLAGS;
    else
      flags_q <= flags_d;
  end

  // built from next flags so a taken vector drops its request at once
  // R1 R2 R3 R4 R5 R6 R7 R8 R9 R10 request gating
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      irqReq_q <= `TMIF_RST_FLAGS;
    else
      irqReq_q <= effEn & flags_d & {`TMIF_NUM_SRC{globalIntEnable}};
  end

  assign irqReq = irqReq_q;

  wire [7:0] stdFlagRd = {2'b00, flags_q[0], flags_q[1], flags_q[2],
                          flags_q[3], 2'b00};
  // R23 extended flag read layout
  wire [7:0] extFlagRd = {2'b00, flags_q[4], flags_q[5], flags_q[6],
                          flags_q[7], flags_q[8], flags_q[9]};
  // R12 legacy reads zero
  wire [7:0] extEnRd = legacyMode ? 8'h00 : {2'b00, extIntEnable_q};
  wire [7:0] rdData = hitEn ? intEnable_q :
                      hitExtEn ? extEnRd :
                      hitFlag ? stdFlagRd :
                      hitExtFlag ? extFlagRd : 8'h00;

  // read data captured in setup, valid through the access phase
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      prdata_q <= `TMIF_RST_PRDATA;
    else if (setupPh & ~pwrite)
      prdata_q <= {24'h000000, rdData};
  end

  assign prdata = prdata_q;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  sequence s_t1MatchA;
    timerTick[0] && timerCounter[0] == compareAValue[0];
  endsequence

  sequence s_t1MatchB;
    timerTick[0] && timerCounter[0] == compareBValue[0];
  endsequence

  sequence s_armedTickA;
    timerTick[0] && g_tmr[0].pend_q[0];
  endsequence

  sequence s_t1PinRise;
    pinSync2_q[0] && !pinLast_q[0] && !g_tmr[0].capTop;
  endsequence

  property p_t1CapReq;
    irqReq[`TMIF_SRC_T1_CAP] |-> flags_q[`TMIF_SRC_T1_CAP] &&
      $past(globalIntEnable && intEnable_q[`TMIF_BIT_CAP]);
  endproperty
  a_t1CapReq: assert property (p_t1CapReq) // R1
    else $error("t1 capture request without cause");

  property p_t1CmpBReq;
    $past(globalIntEnable && intEnable_q[`TMIF_BIT_CMPB]) &&
      flags_q[`TMIF_SRC_T1_CMPB] |-> irqReq[`TMIF_SRC_T1_CMPB];
  endproperty
  a_t1CmpBReq: assert property (p_t1CmpBReq) // R3
    else $error("t1 compare B request missing");

  property p_t1OvfReq;
    irqReq[`TMIF_SRC_T1_OVF] |-> flags_q[`TMIF_SRC_T1_OVF] &&
      $past(globalIntEnable && intEnable_q[`TMIF_BIT_OVF]);
  endproperty
  a_t1OvfReq: assert property (p_t1OvfReq) // R4
    else $error("t1 overflow request without cause");

  property p_t3CapReq;
    irqReq[`TMIF_SRC_T3_CAP] |-> flags_q[`TMIF_SRC_T3_CAP] &&
      $past(globalIntEnable && extIntEnable_q[`TMIF_BIT_CAP]);
  endproperty
  a_t3CapReq: assert property (p_t3CapReq) // R5
    else $error("t3 capture request without cause");

  property p_t1CmpCReq;
    irqReq[`TMIF_SRC_T1_CMPC] |-> flags_q[`TMIF_SRC_T1_CMPC] &&
      $past(globalIntEnable && extIntEnable_q[`TMIF_BIT_T1_CMPC]);
  endproperty
  a_t1CmpCReq: assert property (p_t1CmpCReq) // R10
    else $error("t1 compare C request without cause");

  property p_legacyNoExt;
    legacyMode |=> irqReq[9:4] == 6'h00;
  endproperty
  a_legacyNoExt: assert property (p_legacyNoExt) // R12
    else $error("extended request raised in legacy mode");

  property p_t1PinCap;
    s_t1PinRise |=> flags_q[`TMIF_SRC_T1_CAP];
  endproperty
  a_t1PinCap: assert property (p_t1PinCap) // R13
    else $error("capture pin edge did not set flag");

  property p_t1CapAck;
    vecAck[`TMIF_SRC_T1_CAP] && !setVec[`TMIF_SRC_T1_CAP]
      |=> !flags_q[`TMIF_SRC_T1_CAP];
  endproperty
  a_t1CapAck: assert property (p_t1CapAck) // R15
    else $error("capture flag kept after vector");

  property p_t1MatchArms;
    s_t1MatchA ##0 s_t1MatchB |=> g_tmr[0].pend_q[1:0] == 2'h3;
  endproperty
  a_t1MatchArms: assert property (p_t1MatchArms) // R17
    else $error("compare match not armed");

  property p_t1CmpASet;
    s_t1MatchA ##1 (!timerTick[0]) [*3] ##1 s_armedTickA
      |=> flags_q[`TMIF_SRC_T1_CMPA];
  endproperty
  a_t1CmpASet: assert property (p_t1CmpASet) // R16
    else $error("compare A flag not set on next tick");

  property p_noEarlyCmpA;
    !flags_q[`TMIF_SRC_T1_CMPA] && !timerTick[0]
      |=> !flags_q[`TMIF_SRC_T1_CMPA];
  endproperty
  a_noEarlyCmpA: assert property (p_noEarlyCmpA) // R16
    else $error("compare A flag set between ticks");

  property p_t1OvfNormal;
    overflowEvt[0] && waveformModeSelect[0] == `TMIF_WGM_NORMAL
      |=> flags_q[`TMIF_SRC_T1_OVF];
  endproperty
  a_t1OvfNormal: assert property (p_t1OvfNormal) // R20
    else $error("overflow in normal mode did not set flag");

  property p_setWins;
    wrFlag && pwdata[`TMIF_BIT_CMPA] && setVec[`TMIF_SRC_T1_CMPA]
      |=> flags_q[`TMIF_SRC_T1_CMPA];
  endproperty
  a_setWins: assert property (p_setWins) // R19
    else $error("event lost to a same-cycle clear");

  property p_zeroKeeps;
    wrFlag && !pwdata[`TMIF_BIT_OVF] && flags_q[`TMIF_SRC_T1_OVF] &&
      !vecAck[`TMIF_SRC_T1_OVF] |=> flags_q[`TMIF_SRC_T1_OVF];
  endproperty
  a_zeroKeeps: assert property (p_zeroKeeps) // R24
    else $error("zero write disturbed overflow flag");

  property p_t3CmpCSet;
    timerTick[1] && g_tmr[1].pend_q[2] |=> flags_q[`TMIF_SRC_T3_CMPC];
  endproperty
  a_t3CmpCSet: assert property (p_t3CmpCSet) // R22
    else $error("t3 compare C flag not set");

  property p_extFlagRead;
    setupPh && !pwrite && hitExtFlag
      |=> prdata[5:0] == $past(extFlagRd[5:0]) && prdata[7:6] == 2'h0;
  endproperty
  a_extFlagRead: assert property (p_extFlagRead) // R23
    else $error("extended flag read layout wrong");

endmodule

/* File: tmif_core_model.sv */
// core interrupt sequencer model: acknowledges one vector at a time
`timescale 1ns/100ps
module tmif_core_model
  import tmif_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire tmif_src_vec_t irqReq,
  input wire logic ackOn,
  input wire logic [3:0] lat,
  output tmif_src_vec_t vecAck
);
  logic [3:0] waitCnt_q;
  // one-cycle vector pulse
  // lowest index wins, like a fixed-priority vector table
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      vecAck <= '0;
      waitCnt_q <= '0;
    end
    else
    begin
      vecAck <= '0;
      if (!ackOn || irqReq == '0 || vecAck != '0)
        waitCnt_q <= '0;
      else if (waitCnt_q < lat)
        waitCnt_q <= waitCnt_q + 4'h1;
      else
        vecAck <= irqReq & (~irqReq + 10'h001);
    end
  end
endmodule

/* File: testbench.sv */
// self-checking bench for the timer interrupt flag block
`timescale 1ns/100ps
module testbench
  import tmif_pkg::*;
;
  typedef struct {int tm; int kd; int src;} tmif_row_t;
  logic clk_sys, rstn, psel, penable, pwrite, pready, pslverr, gie;
  logic legacy, ackOn, lastErr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] lat;
  logic [1:0] tick, capPin, ovf, mTov;
  logic [1:0][15:0] tCnt, capV, cmpA, cmpB, cmpC;
  tmif_wgm_t [1:0] wgm;
  tmif_src_vec_t vecAck, irqReq;
  int mismatches, cmpCount, n, b;
  logic [11:0] fa;
  // kinds: 0 pin, 1..3 compare A/B/C, 4 overflow, 5 mode ovf, 6 top
  tmif_row_t rows [10] = '{'{0,0,0}, '{0,1,1}, '{0,2,2}, '{0,4,3},
    '{1,0,4}, '{1,1,5}, '{1,2,6}, '{1,4,7}, '{1,3,8}, '{0,3,9}};

  tmif_ctrl tmif_ctrl_i (.clk_sys(clk_sys), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .globalIntEnable(gie), .legacyModePin(legacy), .vecAck(vecAck),
    .timerTick(tick), .capturePin(capPin), .timerCounter(tCnt),
    .captureValue(capV), .compareAValue(cmpA), .compareBValue(cmpB),
    .compareCValue(cmpC), .waveformModeSelect(wgm), .overflowEvt(ovf),
    .modeTovEvt(mTov), .irqReq(irqReq));

  tmif_core_model tmif_core_model_i (.clk_sys(clk_sys), .rstn(rstn),
    .irqReq(irqReq), .ackOn(ackOn), .lat(lat), .vecAck(vecAck));

  task automatic close_out();
    $display("compares %0d mismatches %0d", cmpCount, mismatches);
    if (mismatches == 0 && cmpCount > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] s);
    cmpCount++;
    if (s !== e)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask

  // called right after a rising edge; holds the request until pready
  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] q);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1 && k < 20)
    begin
      @(posedge clk_sys);
      k++;
    end
    q = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    chk($sformatf("reg %h", a), e, q);
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] q;
    apb(1'b1, a, {24'h0, d}, q);
  endtask

  task automatic fire(input int tm, input int kd);
    if (kd == 0)
    begin
      capPin[tm] <= 1'b1;
      repeat (2) @(posedge clk_sys);
      capPin[tm] <= 1'b0;
    end
    else if (kd >= 4 && kd <= 5)
    begin
      ovf[tm] <= (kd == 4);
      mTov[tm] <= (kd == 5);
      @(posedge clk_sys);
      ovf <= '0;
      mTov <= '0;
    end
    else
    begin
      tCnt[tm] <= kd == 1 ? cmpA[tm] : kd == 2 ? cmpB[tm] :
        kd == 3 ? cmpC[tm] : capV[tm];
      tick[tm] <= 1'b1;
      @(posedge clk_sys);
      tick <= '0;
      tCnt[tm] <= 16'h0000;
      repeat (3) @(posedge clk_sys);
      chk("early irqReq", 32'h0, {22'h0, irqReq});
      tick[tm] <= 1'b1;
      @(posedge clk_sys);
      tick <= '0;
    end
    @(posedge clk_sys);
  endtask

  task automatic wait_irq(input logic want);
    n = 0;
    while ((irqReq != '0) !== want && n < 30)
    begin
      @(posedge clk_sys);
      n++;
    end
  endtask

  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    close_out();
  end

  initial
  begin
    {rstn, psel, penable, pwrite, paddr, pwdata} = '0;
    {gie, legacy, ackOn, lat, tick, capPin, ovf, mTov, tCnt, wgm} = '0;
    cmpA = {2{16'h0111}};
    cmpB = {2{16'h0222}};
    cmpC = {2{16'h0333}};
    capV = {2{16'h0444}};
    repeat (16) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    for (int a = 0; a < 16; a += 4)
      rd(12'(a), 32'h0);
    wr(12'h000, 8'hFF);
    rd(12'h000, 32'hFF);
    wr(12'h000, 8'h3C);
    wr(12'h004, 8'h3F);
    rd(12'h004, 32'h3F);
    gie <= 1'b1;
    foreach (rows[i])
    begin
      b = rows[i].src < 4 ? 5 - rows[i].src : 9 - rows[i].src;
      fa = rows[i].src < 4 ? 12'h008 : 12'h00C;
      fire(rows[i].tm, rows[i].kd);
      wait_irq(1'b1);
      chk("irqReq", 32'h1 << rows[i].src, {22'h0, irqReq});
      rd(fa, 32'h1 << b);
      if (i % 2 == 0)
      begin
        wr(fa, 8'h00);
        rd(fa, 32'h1 << b);
        wr(fa, 8'(1 << b));
      end
      else
      begin
        lat <= 4'(i);
        ackOn <= 1'b1;
        wait_irq(1'b0);
        ackOn <= 1'b0;
      end
      rd(fa, 32'h0);
      $display("row %0d done", i);
    end
    gie <= 1'b0;
    fire(0, 4);
    repeat (3) @(posedge clk_sys);
    chk("irqReq gie off", 32'h0, {22'h0, irqReq});
    gie <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk("irqReq gie on", 32'h8, {22'h0, irqReq});
    wr(12'h000, 8'h38);
    repeat (2) @(posedge clk_sys);
    chk("irqReq masked", 32'h0, {22'h0, irqReq});
    wr(12'h008, 8'h00);
    rd(12'h008, 32'h4);
    wr(12'h008, 8'h04);
    wr(12'h000, 8'h3C);
    $display("global and mask gating done");
    wgm[0] <= 4'h1;
    fire(0, 4);
    rd(12'h008, 32'h0);
    fire(0, 5);
    rd(12'h008, 32'h4);
    wr(12'h008, 8'h04);
    wgm[0] <= 4'hC;
    fire(0, 0);
    repeat (6) @(posedge clk_sys);
    rd(12'h008, 32'h0);
    fire(0, 6);
    rd(12'h008, 32'h20);
    wr(12'h008, 8'h20);
    wgm[0] <= 4'h0;
    $display("waveform modes done");
    legacy <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rd(12'h004, 32'h0);
    wr(12'h004, 8'h00);
    fire(1, 4);
    repeat (3) @(posedge clk_sys);
    chk("irqReq legacy", 32'h0, {22'h0, irqReq});
    rd(12'h00C, 32'h4);
    legacy <= 1'b0;
    repeat (5) @(posedge clk_sys);
    chk("irqReq native", 32'h80, {22'h0, irqReq});
    wr(12'h00C, 8'h04);
    $display("legacy mode done");
    wr(12'h010, 8'h3F);
    chk("pslverr", 32'h1, {31'h0, lastErr});
    rd(12'h010, 32'h0);
    rd(12'h000, 32'h3C);
    rstn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    rd(12'h000, 32'h0);
    rd(12'h004, 32'h0);
    $display("unmapped and second reset done");
    close_out();
  end
endmodule
